//--- cpu_core_pkg.sv
`default_nettype none
package cpu_core_pkg;
  // Control register selector for moves to and from control space
  typedef enum logic [2:0] {
    CtlIsp,
    CtlUsp,
    CtlIntb,
    CtlPc,
    CtlPsw,
    CtlBpc,
    CtlBpsw,
    CtlFintv
  } ctl_sel_e;

  // One register-file write port request
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } gpr_wr_s;

  // Control register write request
  typedef struct packed {
    logic en;
    ctl_sel_e sel;
    logic [31:0] data;
  } ctl_wr_s;

  // Program flow request from the pipeline
  typedef struct packed {
    logic advance;
    logic branch;
    logic [31:0] target;
    logic [31:0] nextPc;
    logic pswWrite;
    logic [31:0] pswData;
  } flow_s;
endpackage
`default_nettype wire

//--- cpu_core_register_set.sv
`default_nettype none
`include "cpu_core_regs.svh"
module cpu_core_register_set
  import cpu_core_pkg::*;
#(
  parameter int WIDTH = `CORE_DATA_W,
  parameter int IDXW = `CORE_GPR_IDX_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic external_reset_n,
  // Operand reads from the decoder
  input wire logic [IDXW-1:0] rdIdxA,
  input wire logic [IDXW-1:0] rdIdxB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB,
  // Result write from the pipeline
  input wire gpr_wr_s gprWr,
  // Control register moves
  input wire ctl_wr_s ctlWr,
  input wire ctl_sel_e ctlRdSel,
  output logic [WIDTH-1:0] ctlRdData,
  // Program flow
  input wire flow_s flow,
  // Fast interrupt controller
  input wire logic fastIntTake,
  input wire logic fastIntReturn,
  // Visible state
  output logic [WIDTH-1:0] programCounter,
  output logic [WIDTH-1:0] processorStatusWord,
  output logic [WIDTH-1:0] activeStackPointer,
  output logic [WIDTH-1:0] vectorTableBase,
  output logic stackSelectUser
);
  // ==========================================================
  // Reset synchroniser: asserts at once, releases after two edges
  logic [2:0] rstSync_r;
  logic rst;
  logic rstPin;

  assign rstPin = ~external_reset_n;

  always_ff @(posedge ref_clk or posedge rstPin) begin
    if (rstPin) begin
      rstSync_r <= `CORE_RST_SYNC_SET;
    end else begin
      rstSync_r <= {rstSync_r[1:0], 1'b0};
    end
  end

  // Held while the second and third stages are both set; released once either clears
  assign rst = rstSync_r[2] & rstSync_r[1];

  // ==========================================================
  // Control state
  typedef struct packed {
    logic [WIDTH-1:0] interrupt_stack_pointer;
    logic [WIDTH-1:0] user_stack_pointer;
    logic [WIDTH-1:0] vector_table_base;
    logic [WIDTH-1:0] pc;
    logic [WIDTH-1:0] processor_status_word;
    logic [WIDTH-1:0] backup_program_counter;
    logic [WIDTH-1:0] backup_status_word;
    logic [WIDTH-1:0] fast_vector_address;
  } ctl_state_s;

  ctl_state_s state_r;
  ctl_state_s state_nxt;

  function automatic logic isStackIdx(input logic [IDXW-1:0] idx);
    return idx == `CORE_SP_INDEX;
  endfunction

  function automatic logic userSel(input logic [WIDTH-1:0] processor_status_word);
    return processor_status_word[`PSW_STACK_SEL];
  endfunction

  // ==========================================================
  // General registers; slot zero unused, the banked pointers stand in
  // Read indices delayed to line up with the registered memory data
  typedef struct packed {
    logic [IDXW-1:0] idxA;
    logic [IDXW-1:0] idxB;
  } rd_state_s;

  rd_state_s rd_r;
  rd_state_s rd_nxt;
  logic [WIDTH-1:0] memA;
  logic [WIDTH-1:0] memB;
  logic memWrEn;

  assign memWrEn = gprWr.en && !isStackIdx(gprWr.idx);

  gpr_memory #(
    .DEPTH(`CORE_GPR_NUM),
    .WIDTH(WIDTH),
    .AW(IDXW)
  ) uMem (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(memWrEn),
    .wrIdx(gprWr.idx),
    .wrData(gprWr.data),
    .rdIdxA(rdIdxA),
    .rdIdxB(rdIdxB),
    .rdDataA(memA),
    .rdDataB(memB)
  );

  always_comb begin
    rd_nxt = rd_r;
    rd_nxt.idxA = rdIdxA;
    rd_nxt.idxB = rdIdxB;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // ==========================================================
  // Operand outputs
  // Stack pointer seen one cycle after the read request
  // The bank follows the select bit as it stands now, so a bank switch
  // between request and answer shows the newly selected pointer
  assign activeStackPointer = userSel(state_r.processor_status_word) ? state_r.user_stack_pointer : state_r.interrupt_stack_pointer;
  assign rdDataA = isStackIdx(rd_r.idxA) ? activeStackPointer : memA;
  assign rdDataB = isStackIdx(rd_r.idxB) ? activeStackPointer : memB;

  // ==========================================================
  // Next state; priority: fast take, fast return, flow, moves
  // Later assignments win, so the order of the blocks below is the
  // priority order; moving one changes which request survives a clash
  always_comb begin
    state_nxt = state_r;
    // Register zero writes reach the selected bank
    if (gprWr.en && isStackIdx(gprWr.idx)) begin
      if (userSel(state_r.processor_status_word)) begin
        state_nxt.user_stack_pointer = gprWr.data;
      end else begin
        state_nxt.interrupt_stack_pointer = gprWr.data;
      end
    end
    if (ctlWr.en) begin
      case (ctlWr.sel)
        CtlIsp: state_nxt.interrupt_stack_pointer = ctlWr.data;
        CtlUsp: state_nxt.user_stack_pointer = ctlWr.data;
        CtlIntb: state_nxt.vector_table_base = ctlWr.data;
        CtlPc: state_nxt.pc = ctlWr.data;
        CtlPsw: state_nxt.processor_status_word = ctlWr.data;
        CtlBpc: state_nxt.backup_program_counter = ctlWr.data;
        CtlBpsw: state_nxt.backup_status_word = ctlWr.data;
        CtlFintv: state_nxt.fast_vector_address = ctlWr.data;
        default: state_nxt = state_r;
      endcase
    end
    if (flow.pswWrite) begin
      state_nxt.processor_status_word = flow.pswData;
    end
    if (flow.branch) begin
      state_nxt.pc = flow.target;
    end else if (flow.advance) begin
      state_nxt.pc = flow.nextPc;
    end
    // Fast entry saves the state as it stood before this edge
    if (fastIntTake) begin
      state_nxt.backup_program_counter = state_r.pc;
      state_nxt.backup_status_word = state_r.processor_status_word;
      state_nxt.pc = state_r.fast_vector_address;
    end else if (fastIntReturn) begin
      state_nxt.pc = state_r.backup_program_counter;
      state_nxt.processor_status_word = state_r.backup_status_word;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= '{interrupt_stack_pointer: `CORE_RESET_WORD, user_stack_pointer: `CORE_RESET_WORD, vector_table_base: `CORE_RESET_WORD,
                   pc: `CORE_RESET_PC, processor_status_word: `CORE_RESET_PSW, backup_program_counter: `CORE_RESET_WORD,
                   backup_status_word: `CORE_RESET_PSW, fast_vector_address: `CORE_RESET_WORD};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Control register read mux
  always_comb begin
    case (ctlRdSel)
      CtlIsp: ctlRdData = state_r.interrupt_stack_pointer;
      CtlUsp: ctlRdData = state_r.user_stack_pointer;
      CtlIntb: ctlRdData = state_r.vector_table_base;
      CtlPc: ctlRdData = state_r.pc;
      CtlPsw: ctlRdData = state_r.processor_status_word;
      CtlBpc: ctlRdData = state_r.backup_program_counter;
      CtlBpsw: ctlRdData = state_r.backup_status_word;
      CtlFintv: ctlRdData = state_r.fast_vector_address;
      default: ctlRdData = `CORE_RESET_WORD;
    endcase
  end

  // ==========================================================
  // Visible state
  assign programCounter = state_r.pc;
  assign processorStatusWord = state_r.processor_status_word;
  assign vectorTableBase = state_r.vector_table_base;
  assign stackSelectUser = userSel(state_r.processor_status_word);
endmodule
`default_nettype wire

//--- cpu_core_register_set_sva.sv
`default_nettype none
module cpu_core_register_set_sva
  import cpu_core_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int IDXW = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic external_reset_n,
  // Operand and control traffic
  input wire logic [IDXW-1:0] rdIdxA,
  input wire logic [WIDTH-1:0] rdDataA,
  input wire gpr_wr_s gprWr,
  input wire ctl_sel_e ctlRdSel,
  input wire logic [WIDTH-1:0] ctlRdData,
  input wire flow_s flow,
  input wire logic fastIntTake,
  input wire logic fastIntReturn,
  // Visible state
  input wire logic [WIDTH-1:0] programCounter,
  input wire logic [WIDTH-1:0] processorStatusWord,
  input wire logic [WIDTH-1:0] activeStackPointer,
  input wire logic stackSelectUser
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!external_reset_n);
  // ==========================================
  // Properties
  sequence s_wr_rd;
    gprWr.en && gprWr.idx != 4'h0 ##1 rdIdxA == $past(gprWr.idx) && !gprWr.en;
  endsequence
  property p_rd;
    s_wr_rd |=> rdDataA == $past(gprWr.data, 2);
  endproperty
  a_rd: assert property (p_rd) else $error("read data differs from write");
  property p_sp;
    (ctlRdSel == CtlUsp && stackSelectUser) || (ctlRdSel == CtlIsp && !stackSelectUser)
      |-> activeStackPointer == ctlRdData;
  endproperty
  a_sp: assert property (p_sp) else $error("wrong stack pointer bank");
  property p_adv;
    flow.advance && !flow.branch && !fastIntTake && !fastIntReturn |=> programCounter == $past(flow.nextPc);
  endproperty
  a_adv: assert property (p_adv) else $error("pc did not advance");
  property p_sel;
    stackSelectUser == processorStatusWord[17];
  endproperty
  a_sel: assert property (p_sel) else $error("stack select bit mismatch");
  property p_bpc;
    fastIntTake ##1 ctlRdSel == CtlBpc |-> ctlRdData == $past(programCounter);
  endproperty
  a_bpc: assert property (p_bpc) else $error("backup pc not saved");
  property p_backup_status_word;
    fastIntTake ##2 (ctlRdSel == CtlBpsw && !$past(fastIntTake)) |-> ctlRdData == $past(processorStatusWord, 2);
  endproperty
  a_backup_status_word: assert property (p_backup_status_word) else $error("backup status not saved");
  property p_vec;
    fastIntTake && ctlRdSel == CtlFintv |=> programCounter == $past(ctlRdData);
  endproperty
  a_vec: assert property (p_vec) else $error("fast vector not taken");
  property p_ret;
    fastIntReturn && ctlRdSel == CtlBpc |=> programCounter == $past(ctlRdData);
  endproperty
  a_ret: assert property (p_ret) else $error("pc not restored");
endmodule
bind cpu_core_register_set cpu_core_register_set_sva #(.WIDTH(WIDTH), .IDXW(IDXW)) sva_u (.ref_clk,
  .external_reset_n, .rdIdxA, .rdDataA, .gprWr, .ctlRdSel, .ctlRdData, .flow, .fastIntTake,
  .fastIntReturn, .programCounter, .processorStatusWord, .activeStackPointer, .stackSelectUser);
`default_nettype wire

//--- cpu_core_register_set_tb.sv
`default_nettype none
module cpu_core_register_set_tb
  import cpu_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic resetN = 1'b0;
  logic [3:0] rdIdxA = 4'h0;
  logic [3:0] rdIdxB = 4'h0;
  gpr_wr_s gprWr = '0;
  ctl_wr_s ctlWr = '0;
  ctl_sel_e ctlRdSel = CtlIsp;
  flow_s flow = '0;
  logic fire = 1'b0;
  logic retire = 1'b0;
  logic fastIntTake, fastIntReturn, stackSelectUser;
  logic [31:0] rdDataA, rdDataB, ctlRdData, pc, processor_status_word, sp, vtb;
  int failCount = 0;
  int checksDone = 0;
  always #5 ref_clk = ~ref_clk;
  // ==========================================
  // Instances
  fast_irq_model irq_u (.ref_clk(ref_clk), .rstN(resetN), .fire(fire), .retire(retire),
    .fastIntTake(fastIntTake), .fastIntReturn(fastIntReturn));
  cpu_core_register_set dut_u (.ref_clk(ref_clk), .external_reset_n(resetN), .rdIdxA(rdIdxA),
    .rdIdxB(rdIdxB), .rdDataA(rdDataA), .rdDataB(rdDataB), .gprWr(gprWr), .ctlWr(ctlWr),
    .ctlRdSel(ctlRdSel), .ctlRdData(ctlRdData), .flow(flow), .fastIntTake(fastIntTake),
    .fastIntReturn(fastIntReturn), .programCounter(pc), .processorStatusWord(processor_status_word),
    .activeStackPointer(sp), .vectorTableBase(vtb), .stackSelectUser(stackSelectUser));
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic idle;
    gprWr = '0;
    ctlWr = '0;
    flow = '0;
    step;
  endtask
  task automatic go(input logic a, input logic b, input logic w, input logic [31:0] t, input logic [31:0] p);
    flow = '{a, b, t, t, w, p};
    step;
  endtask
  task automatic do_reset;
    resetN = 1'b0;
    repeat (6) step;
    resetN = 1'b1;
    repeat (4) step;
  endtask
  task automatic complete_run;
    if (failCount == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk(pc | processor_status_word | sp | vtb, 32'h0);
    chk({31'h0, stackSelectUser}, 32'h0);
  endtask
  task automatic t_gpr;
    for (int k = 1; k < 16; k++) begin
      gprWr = '{1'b1, 4'(k), 32'hA5A5_0000 | 32'(k)};
      step;
      rdIdxA = 4'(k);
      rdIdxB = 4'(k);
      idle;
      chk(rdDataA, 32'hA5A5_0000 | 32'(k));
      chk(rdDataB, 32'hA5A5_0000 | 32'(k));
    end
  endtask
  task automatic t_bank;
    rdIdxA = 4'h0;
    gprWr = '{1'b1, 4'h0, 32'h0000_2000};
    step;
    gprWr = '0;
    go(1'b0, 1'b0, 1'b1, 32'h0, 32'h0002_0000);
    gprWr = '{1'b1, 4'h0, 32'h0000_3000};
    step;
    idle;
    chk(processor_status_word, 32'h0002_0000);
    chk(sp, 32'h0000_3000);
    chk(rdDataA, 32'h0000_3000);
    ctlRdSel = CtlIsp;
    #1;
    chk(ctlRdData, 32'h0000_2000);
  endtask
  task automatic t_ctl;
    ctlWr = '{1'b1, CtlIntb, 32'h0000_8000};
    step;
    ctlWr = '{1'b1, CtlFintv, 32'h0000_F000};
    step;
    idle;
    chk(vtb, 32'h0000_8000);
    go(1'b0, 1'b1, 1'b0, 32'h0000_1000, 32'h0);
    chk(pc, 32'h0000_1000);
    go(1'b1, 1'b0, 1'b0, 32'h0000_1004, 32'h0);
    idle;
    chk(pc, 32'h0000_1004);
  endtask
  task automatic t_fast;
    ctlRdSel = CtlFintv;
    fire = 1'b1;
    step;
    chk(pc, 32'h0000_F000);
    fire = 1'b0;
    ctlRdSel = CtlBpc;
    #1;
    chk(ctlRdData, 32'h0000_1004);
    step;
    ctlRdSel = CtlBpsw;
    #1;
    chk(ctlRdData, 32'h0002_0000);
    go(1'b0, 1'b0, 1'b1, 32'h0, 32'h0000_000F);
    ctlRdSel = CtlBpc;
    retire = 1'b1;
    idle;
    retire = 1'b0;
    chk(pc, 32'h0000_1004);
    chk(processor_status_word, 32'h0002_0000);
  endtask
  task automatic t_moves;
    for (int k = 0; k < 8; k++) begin
      ctlWr = '{1'b1, ctl_sel_e'(k), 32'h0000_0100 << k};
      step;
    end
    idle;
    for (int k = 0; k < 8; k++) begin
      ctlRdSel = ctl_sel_e'(k);
      #1;
      chk(ctlRdData, 32'h0000_0100 << k);
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    failCount++;
    $display("Error at %0t: run hung", $time);
    complete_run;
  end
  initial begin
    do_reset;
    t_reset;
    t_gpr;
    t_bank;
    t_ctl;
    t_fast;
    t_moves;
    resetN = 1'b0;
    #1;
    t_reset;
    do_reset;
    t_reset;
    complete_run;
  end
endmodule
`default_nettype wire

//--- cpu_core_regs.svh
`ifndef CPU_CORE_REGS_SVH
`define CPU_CORE_REGS_SVH
// Register geometry
`define CORE_DATA_W 32
`define CORE_GPR_NUM 16
`define CORE_GPR_IDX_W 4
`define CORE_SP_INDEX 4'h0
// Reset synchroniser load value
`define CORE_RST_SYNC_SET 3'h7
// Status word field positions
`define PSW_FLAG_C 0
`define PSW_FLAG_Z 1
`define PSW_FLAG_S 2
`define PSW_FLAG_O 3
`define PSW_STACK_SEL 17
// Reset values
`define CORE_RESET_WORD 32'h0000_0000
`define CORE_RESET_PC 32'h0000_0000
`define CORE_RESET_PSW 32'h0000_0000
`endif

//--- fast_irq_model.sv
`default_nettype none
module fast_irq_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // Requests from the bench
  input wire logic fire,
  input wire logic retire,
  // Pulses to the core
  output logic fastIntTake,
  output logic fastIntReturn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic fireSeen_r;
  logic retSeen_r;
  // One pulse per request, however long it is held
  assign fastIntTake = fire & ~fireSeen_r;
  assign fastIntReturn = retire & ~retSeen_r;
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      fireSeen_r <= 1'b0;
      retSeen_r <= 1'b0;
    end else begin
      fireSeen_r <= fire;
      retSeen_r <= retire;
    end
  end
endmodule
`default_nettype wire

//--- gpr_memory.sv
`default_nettype none
`include "cpu_core_regs.svh"
module gpr_memory #(
  parameter int DEPTH = `CORE_GPR_NUM,
  parameter int WIDTH = `CORE_DATA_W,
  parameter int AW = `CORE_GPR_IDX_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // Two registered read ports
  input wire logic [AW-1:0] rdIdxA,
  input wire logic [AW-1:0] rdIdxB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB
);
  // ==========================================================
  // Storage
  logic [DEPTH-1:0][WIDTH-1:0] mem_r;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gCell
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          mem_r[g] <= `CORE_RESET_WORD;
        end else if (wrEn && wrIdx == AW'(g)) begin
          mem_r[g] <= wrData;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Registered reads
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdDataA <= `CORE_RESET_WORD;
      rdDataB <= `CORE_RESET_WORD;
    end else begin
      rdDataA <= mem_r[rdIdxA];
      rdDataB <= mem_r[rdIdxB];
    end
  end
endmodule
`default_nettype wire
